// ---- bench/mrf_master_model.sv ----
`default_nettype none
// ----------------------------------------
// bus master standing in front of the front end
// ----------------------------------------
module mrf_master_model
	import mrf_pkg::*;
(
	input wire logic clock,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic [63:0] rsp_rdata,
	input wire mrf_resp_t rsp_code,
	output var logic req_valid,
	output var logic req_write,
	output var logic [12:0] req_addr,
	output var mrf_size_t req_size,
	output var logic [63:0] req_wdata,
	output var logic rsp_ready
);
	timeunit 1ns;
	timeprecision 100ps;

	// idle bus at time zero
	initial begin
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = 13'h0000;
		req_size = MRF_SZ_32;
		req_wdata = 64'h0;
		rsp_ready = 1'b0;
	end

	// one transfer; stall holds off the reply acceptance for that many cycles
	task automatic access(input logic wr, input logic [12:0] a, input mrf_size_t sz, input logic [63:0] wd,
		input int stall, output logic [63:0] rd, output mrf_resp_t rc);
		int n;
		logic done;
		@(posedge clock);
		req_valid <= 1'b1;
		req_write <= wr;
		req_addr <= a;
		req_size <= sz;
		req_wdata <= wd;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (!req_ready && n < 20);
		// released lines show garbage so stale values cannot pass
		req_valid <= 1'b0;
		req_write <= ~wr;
		req_addr <= ~a;
		req_size <= mrf_size_t'(~sz);
		req_wdata <= ~wd;
		rsp_ready <= (stall == 0);
		done = 1'b0;
		for (n = 0; n < 30; n++) begin
			@(posedge clock);
			if (rsp_ready && rsp_valid) begin
				done = 1'b1;
				break;
			end
			rsp_ready <= (n + 1 >= stall);
		end
		rd = rsp_rdata;
		// a reply that never came shows a code no access can give, so the bench counts it
		rc = done ? rsp_code : mrf_resp_t'(2'b11);
		rsp_ready <= 1'b0;
	endtask : access
endmodule : mrf_master_model
`default_nettype wire

// ---- bench/test_mmio_register_access_front_end.sv ----
`default_nettype none
`include "mrf_cfg.svh"
module test_mmio_register_access_front_end
	import mrf_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {
		logic wr;
		logic [12:0] a;
		mrf_size_t sz;
		logic [63:0] wd;
		logic [63:0] rd;
		mrf_resp_t rc;
	} mrf_row_t;
	localparam mrf_resp_t ok = MRF_RSP_OKAY;
	localparam mrf_resp_t ab = MRF_RSP_ABORT;
	localparam mrf_size_t s8 = MRF_SZ_8;
	localparam mrf_size_t s16 = MRF_SZ_16;
	localparam mrf_size_t s32 = MRF_SZ_32;
	localparam mrf_size_t s64 = MRF_SZ_64;
	logic clock, rst_b, req_valid, req_ready, req_write, rsp_valid, rsp_ready;
	logic [12:0] req_addr;
	mrf_size_t req_size;
	logic [63:0] req_wdata, rsp_rdata, rd;
	mrf_resp_t rsp_code, rc;
	int failures = 0;
	int n_compared = 0;
	int cycles = 0;
	// rows run in order: later rows rely on state left by earlier ones
	mrf_row_t rows [27] = '{
		'{1'b1, 13'h0000, s32, 64'hffff_ffff, 64'h0, ok},
		'{1'b0, 13'h0000, s32, 64'h0, 64'hff, ok},
		'{1'b0, 13'h1000, s32, 64'h0, 64'h0, ok},
		'{1'b1, 13'h0008, s64, 64'h1234_5678_9abc_d000, 64'h0, ok},
		'{1'b0, 13'h000c, s32, 64'h0, 64'h1234_5678, ok},
		'{1'b0, 13'h0008, s32, 64'h0, 64'h9abc_d000, ok},
		'{1'b1, 13'h0008, s32, 64'h9abc_d001, 64'h0, ok},
		'{1'b0, 13'h0004, s32, 64'h0, 64'h1, ok},
		'{1'b0, 13'h1004, s32, 64'h0, 64'h0, ok},
		'{1'b1, 13'h0008, s64, 64'hffff_ffff_ffff_f001, 64'h0, ok},
		'{1'b0, 13'h0008, s64, 64'h0, 64'h1234_5678_9abc_d001, ok},
		'{1'b1, 13'h0004, s32, 64'h0, 64'h0, ok},
		'{1'b0, 13'h0004, s32, 64'h0, 64'h1, ok},
		'{1'b0, 13'h0024, s32, 64'h0, {32'h0, `MRF_RO_ID_VAL}, ok},
		'{1'b1, 13'h0020, s32, 64'h5, 64'h0, ok},
		'{1'b0, 13'h0020, s32, 64'h0, 64'h0, ok},
		'{1'b1, 13'h0030, s32, 64'h7, 64'h0, ok},
		'{1'b0, 13'h0030, s32, 64'h0, 64'h0, ok},
		'{1'b1, 13'h0018, s64, 64'haaaa_bbbb_cccc_dddd, 64'h0, ok},
		'{1'b0, 13'h001c, s32, 64'h0, 64'haaaa_bbbb, ok},
		'{1'b0, 13'h0000, s8, 64'h0, 64'h0, ab},
		'{1'b1, 13'h0010, s16, 64'h3, 64'h0, ok},
		'{1'b1, 13'h0000, s16, 64'h0, 64'h0, ab},
		'{1'b1, 13'h001a, s32, 64'h0, 64'h0, ab},
		'{1'b0, 13'h0018, s32, 64'h0, 64'hcccc_dddd, ok},
		'{1'b1, 13'h000c, s64, 64'h0, 64'h0, ab},
		'{1'b0, 13'h0000, s32, 64'h0, 64'hff, ok}
	};

	mrf_front #(.FRAMES(2), .FRAME_BITS(12)) dut (.clock(clock), .rst_b(rst_b), .req_valid(req_valid),
		.req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_size(req_size),
		.req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_rdata(rsp_rdata),
		.rsp_code(rsp_code));
	mrf_master_model m (.clock(clock), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.rsp_code(rsp_code), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
		.req_size(req_size), .req_wdata(req_wdata), .rsp_ready(rsp_ready));

	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic report_and_stop();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop

	// 200 MHz clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// hang guard: the whole run needs well under two hundred cycles
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			report_and_stop();
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst_b = 1'b0;
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		// stall of 0, 1 or 2 mixes prompt and slow reply acceptance
		foreach (rows[i]) begin
			m.access(rows[i].wr, rows[i].a, rows[i].sz, rows[i].wd, i % 3, rd, rc);
			chk(rd, rows[i].rd, "reply data");
			chk({62'h0, rc}, {62'h0, rows[i].rc}, "reply code");
		end
		// reset in mid-run clears storage and the reply path
		@(posedge clock);
		rst_b <= 1'b0;
		@(posedge clock);
		#1;
		chk({63'h0, req_ready}, 64'h1, "ready in reset");
		chk({63'h0, rsp_valid}, 64'h0, "reply in reset");
		@(posedge clock);
		rst_b <= 1'b1;
		m.access(1'b0, 13'h0000, s32, 64'h0, 0, rd, rc);
		chk(rd, {32'h0, `MRF_CTRL_RST}, "control after reset");
		chk({62'h0, rc}, {62'h0, ok}, "control code after reset");
		m.access(1'b0, 13'h0008, s64, 64'h0, 1, rd, rc);
		chk(rd, `MRF_BASE_RST, "base after reset");
		chk({62'h0, rc}, {62'h0, ok}, "base code after reset");
		report_and_stop();
	end
endmodule : test_mmio_register_access_front_end
`default_nettype wire

// ---- core/mrf_cfg.svh ----
`ifndef MRF_CFG_SVH
`define MRF_CFG_SVH
// register frame layout (byte offsets inside one frame)
`define MRF_OFF_CTRL 12'h000
`define MRF_OFF_STATUS 12'h004
`define MRF_OFF_BASE_LO 12'h008
`define MRF_OFF_BASE_HI 12'h00c
`define MRF_OFF_XLATE 12'h010
`define MRF_OFF_XLATE_ALT 12'h014
`define MRF_OFF_SCRATCH0 12'h018
`define MRF_OFF_SCRATCH1 12'h01c
`define MRF_OFF_WO 12'h020
`define MRF_OFF_RO_ID 12'h024
// field positions
`define MRF_CTRL_VALID_BIT 0
`define MRF_CTRL_MASK 32'h0000_00ff
`define MRF_BASE_VALID_BIT 0
`define MRF_BASE_ADDR_MASK 64'hffff_ffff_ffff_f000
// reset values
`define MRF_CTRL_RST 32'h0000_0000
`define MRF_BASE_RST 64'h0000_0000_0000_0000
`define MRF_SCRATCH_RST 32'h0000_0000
`define MRF_RO_ID_VAL 32'h0000_5a01
`endif

// ---- core/mrf_frame.sv ----
`default_nettype none
`include "mrf_cfg.svh"
// one register frame: the storage that the front end decodes into
module mrf_frame
	import mrf_pkg::*;
#(
	parameter int IDX = 0
) (
	input wire logic clock,
	input wire logic rst_b,
	mrf_wr_if.frm bus
);
	logic [31:0] ctrl_r;
	logic [63:0] base_r;
	logic [31:0] scratch_r [2];
	logic [31:0] xlate_r;
	logic sel;
	logic we;
	logic base_guard_open;
	logic [63:0] base_nxt;
	logic [63:0] bmask;
	logic [63:0] rd_word;

	assign sel = bus.frame_sel[IDX];
	assign we = bus.wen && sel;
	// byte strobes widened to a bit mask
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_mask
			assign bmask[g*8 +: 8] = {8{bus.wstrb[g]}};
		end
	endgenerate

	// the base address only moves while this frame's own valid bit is clear
	assign base_guard_open = !base_r[`MRF_BASE_VALID_BIT];
	// guarded address bits frozen while valid is set; valid itself stays writable
	assign base_nxt = base_guard_open ?
		((base_r & ~bmask) | (bus.wdata & bmask)) :
		((base_r & ~(bmask & ~`MRF_BASE_ADDR_MASK)) | (bus.wdata & bmask & ~`MRF_BASE_ADDR_MASK));

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r <= `MRF_CTRL_RST;
			base_r <= `MRF_BASE_RST;
			scratch_r[0] <= `MRF_SCRATCH_RST;
			scratch_r[1] <= `MRF_SCRATCH_RST;
			xlate_r <= 32'h0000_0000;
		end else if (we) begin
			// a 64-bit write lands whole in one edge, so no reader sees half of it
			case (bus.offset)
				`MRF_OFF_CTRL: ctrl_r <= ((ctrl_r & ~bmask[31:0]) | (bus.wdata[31:0] & bmask[31:0])) & `MRF_CTRL_MASK;
				`MRF_OFF_BASE_LO: base_r <= base_nxt;
				`MRF_OFF_BASE_HI: base_r <= base_nxt;
				`MRF_OFF_XLATE, `MRF_OFF_XLATE_ALT: xlate_r <= (xlate_r & ~bmask[31:0]) | (bus.wdata[31:0] & bmask[31:0]);
				// both scratch words share one lane pair; the strobes pick the half that moves
				`MRF_OFF_SCRATCH0: begin
					if (bus.wstrb[0]) begin
						scratch_r[0] <= bus.wdata[31:0];
					end
					if (bus.wstrb[4]) begin
						scratch_r[1] <= bus.wdata[63:32];
					end
				end
				default: ;
			endcase
		end
	end

	// read mux: write-only and translate locations return zero, read-only fixed id
	always_comb begin
		case (bus.offset)
			`MRF_OFF_CTRL: rd_word = {32'h0, ctrl_r};
			`MRF_OFF_STATUS: rd_word = {32'h0, 31'h0, base_r[`MRF_BASE_VALID_BIT]};
			`MRF_OFF_BASE_LO: rd_word = base_r;
			`MRF_OFF_BASE_HI: rd_word = {base_r[31:0], base_r[63:32]};
			`MRF_OFF_SCRATCH0: rd_word = {scratch_r[1], scratch_r[0]};
			`MRF_OFF_SCRATCH1: rd_word = {32'h0, scratch_r[1]};
			`MRF_OFF_RO_ID: rd_word = {32'h0, `MRF_RO_ID_VAL};
			default: rd_word = 64'h0;
		endcase
	end
	assign bus.rdata[IDX] = rd_word;
endmodule : mrf_frame
`default_nettype wire

// ---- core/mrf_front.sv ----
`default_nettype none
`include "mrf_cfg.svh"
// How it works
// - unimplemented locations read zero, writes dropped
// - each field obeys its read/write access type
// - dependent registers come from same frame
// - registers laid out little-endian on bus
// - every register is 32 or 64 bits
// - aligned 32-bit always, 64-bit on wide registers
// - upper word of wide register at +4
// - same-size aligned access is atomic
// - 16-bit only to low half of translate
// - illegal access answered by abort here
// - illegal writes dropped, target left unchanged
// - 64-bit over a 32-bit pair aborts, except the scratch pair, where it hits both
// - guarded field frozen unless guard enables it
// - write to frozen guarded field has no effect
module mrf_front
	import mrf_pkg::*;
#(
	parameter int FRAMES = 2,
	parameter int FRAME_BITS = 12
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [FRAME_BITS+$clog2(FRAMES)-1:0] req_addr,
	input wire mrf_size_t req_size,
	input wire logic [63:0] req_wdata,
	output logic rsp_valid,
	input wire logic rsp_ready,
	output logic [63:0] rsp_rdata,
	output mrf_resp_t rsp_code
);
	localparam int AW = FRAME_BITS + $clog2(FRAMES);

	mrf_wr_if #(.FRAMES(FRAMES)) wif ();
	mrf_state_t state_r;
	mrf_state_t state_nxt;
	logic [63:0] rdata_r;
	mrf_resp_t code_r;
	logic [11:0] off;
	logic [$clog2(FRAMES)-1:0] frame;
	logic take;
	logic is_wide;
	logic is_xlate;
	logic is_known;
	logic upper_word;
	logic legal;
	logic [7:0] strb;
	logic [63:0] lane_wdata;
	logic [63:0] lane_rdata;
	logic [63:0] frame_rdata;

	// -----------------------------------------------------------------
	// decode
	// -----------------------------------------------------------------
	// which locations hold 64-bit registers (the base pair and the scratch pair start)
	function automatic logic wide_at(input logic [11:0] o);
		wide_at = (o == `MRF_OFF_BASE_LO) || (o == `MRF_OFF_SCRATCH0);
	endfunction : wide_at

	function automatic logic known_at(input logic [11:0] o);
		known_at = (o <= `MRF_OFF_RO_ID);
	endfunction : known_at

	assign off = {req_addr[11:3], 3'b000} | {9'h0, req_addr[2], 2'b00};
	assign frame = req_addr[AW-1:FRAME_BITS];
	assign is_wide = wide_at({off[11:3], 3'b000});
	assign is_xlate = (off == `MRF_OFF_XLATE) || (off == `MRF_OFF_XLATE_ALT);
	assign is_known = known_at(off);
	// the supported size and alignment combinations; everything else is illegal
	assign legal = (
		((req_size == MRF_SZ_32) && (req_addr[1:0] == 2'b00)) ||
		((req_size == MRF_SZ_64) && (req_addr[2:0] == 3'b000) &&
			(is_wide || wide_at(off))) ||
		((req_size == MRF_SZ_16) && (req_addr[1:0] == 2'b00) && is_xlate));
	// unimplemented offsets are not aborted, they fall through as zero reads
	assign take = req_valid && req_ready;

	// byte lanes: the upper word of a 64-bit register occupies the upper four lanes, little-endian;
	// a 32-bit register at +4 is a register of its own and keeps the lower lanes
	assign upper_word = req_addr[2] && is_wide && (req_size != MRF_SZ_64);
	assign strb = (req_size == MRF_SZ_64) ? 8'hff :
		(req_size == MRF_SZ_32) ? (upper_word ? 8'hf0 : 8'h0f) :
		8'h03;
	assign lane_wdata = upper_word ? {req_wdata[31:0], 32'h0} : req_wdata;

	// -----------------------------------------------------------------
	// frame strobes
	// -----------------------------------------------------------------
	generate
		for (genvar f = 0; f < FRAMES; f++) begin : g_frame
			// only the addressed frame sees the write, so guards stay frame local
			assign wif.frame_sel[f] = (frame == ($clog2(FRAMES))'(f));
			mrf_frame #(.IDX(f)) u_frame (
				.clock(clock),
				.rst_b(rst_b),
				.bus(wif.frm)
			);
		end
	endgenerate

	assign wif.offset = (req_size == MRF_SZ_64) ? {off[11:3], 3'b000} :
		(is_wide || wide_at({off[11:3], 3'b000}) ? {off[11:3], 3'b000} : off);
	assign wif.wdata = lane_wdata;
	assign wif.wstrb = strb;
	// illegal writes never reach storage, so the aborted access leaves state alone
	assign wif.wen = take && req_write && legal;
	assign frame_rdata = wif.rdata[frame];
	// a 32-bit read of the upper word is moved down to lanes 31:0
	assign lane_rdata = (req_size == MRF_SZ_64) ? frame_rdata :
		(req_size == MRF_SZ_32) ? {32'h0, upper_word ? frame_rdata[63:32] : frame_rdata[31:0]} :
		{48'h0, frame_rdata[15:0]};

	// -----------------------------------------------------------------
	// reply
	// -----------------------------------------------------------------
	// one access in flight; the next is taken only after the reply is accepted
	assign req_ready = (state_r == MRF_IDLE);
	always_comb begin
		case (state_r)
			MRF_IDLE: state_nxt = take ? MRF_RESP : MRF_IDLE;
			MRF_RESP: state_nxt = rsp_ready ? MRF_IDLE : MRF_RESP;
			default: state_nxt = MRF_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= MRF_IDLE;
			rdata_r <= 64'h0;
			code_r <= MRF_RSP_OKAY;
		end else begin
			state_r <= state_nxt;
			if (take) begin
				rdata_r <= (legal && !req_write) ? lane_rdata : 64'h0;
				code_r <= legal ? MRF_RSP_OKAY : MRF_RSP_ABORT;
			end
		end
	end

	assign rsp_valid = (state_r == MRF_RESP);
	assign rsp_rdata = rdata_r;
	assign rsp_code = code_r;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	sequence s_take_illegal;
		req_valid && req_ready && !legal;
	endsequence
	sequence s_abort_reply;
		rsp_valid && (rsp_code == MRF_RSP_ABORT) && (rsp_rdata == 64'h0);
	endsequence

	illegal_abort_a: assert property (@(posedge clock) disable iff (!rst_b)
		s_take_illegal |=> s_abort_reply) else $error("illegal access not aborted");
	abort_no_write_a: assert property (@(posedge clock) disable iff (!rst_b)
		(req_valid && !legal) |-> !wif.wen) else $error("illegal write reached a frame");
	legal_okay_a: assert property (@(posedge clock) disable iff (!rst_b)
		(take && legal) |=> (rsp_valid && rsp_code == MRF_RSP_OKAY)) else $error("legal access aborted");
	half_only_xlate_a: assert property (@(posedge clock) disable iff (!rst_b)
		(take && req_size == MRF_SZ_16 && !is_xlate) |=> rsp_code == MRF_RSP_ABORT)
		else $error("16-bit access accepted off the translate register");
	byte_illegal_a: assert property (@(posedge clock) disable iff (!rst_b)
		(take && req_size == MRF_SZ_8) |=> rsp_code == MRF_RSP_ABORT) else $error("byte access accepted");
	upper_lane_a: assert property (@(posedge clock) disable iff (!rst_b)
		(take && req_size == MRF_SZ_32 && req_addr[2] && is_wide) |-> (wif.wstrb == 8'hf0))
		else $error("upper word not on upper lanes");
	reply_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
		(rsp_valid && !rsp_ready) |=> (rsp_valid && $stable(rsp_rdata) && $stable(rsp_code)))
		else $error("reply dropped before acceptance");
	no_overlap_a: assert property (@(posedge clock) disable iff (!rst_b)
		rsp_valid |-> !req_ready) else $error("second access taken while reply pending");
	unmapped_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
		(take && !req_write && !is_known) |=> rsp_rdata == 64'h0) else $error("unmapped read not zero");
	full_write_a: assert property (@(posedge clock) disable iff (!rst_b)
		(wif.wen && req_size == MRF_SZ_64) |-> wif.wstrb == 8'hff) else $error("64-bit write split");

	// a taken legal access and the okay reply that must follow it on the next edge
	sequence s_take_legal;
		req_valid && req_ready && legal;
	endsequence
	sequence s_okay_reply;
		rsp_valid && (rsp_code == MRF_RSP_OKAY);
	endsequence

	one_frame_a: assert property (@(posedge clock) disable iff (!rst_b)
		$onehot(wif.frame_sel)) else $error("write strobe reaches more than one frame");
	lower_lane_a: assert property (@(posedge clock) disable iff (!rst_b)
		(take && req_size == MRF_SZ_32 && !(req_addr[2] && is_wide)) |-> (wif.wstrb == 8'h0f))
		else $error("32-bit register not on lower lanes");
	misalign_abort_a: assert property (@(posedge clock) disable iff (!rst_b)
		(take && req_size == MRF_SZ_32 && req_addr[1:0] != 2'b00) |=> (rsp_code == MRF_RSP_ABORT))
		else $error("misaligned word access accepted");
	split_wide_a: assert property (@(posedge clock) disable iff (!rst_b)
		(take && req_size == MRF_SZ_64 && req_addr[2]) |=> (rsp_code == MRF_RSP_ABORT))
		else $error("64-bit access at +4 accepted");
	narrow_wide_a: assert property (@(posedge clock) disable iff (!rst_b)
		(take && req_size == MRF_SZ_64 && off == `MRF_OFF_CTRL) |=> (rsp_code == MRF_RSP_ABORT))
		else $error("64-bit access to a 32-bit register accepted");
	unmapped_okay_a: assert property (@(posedge clock) disable iff (!rst_b)
		(take && !is_known && req_size == MRF_SZ_32 && req_addr[1:0] == 2'b00) |=> s_okay_reply)
		else $error("unmapped word access aborted");
	write_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
		(take && req_write) |=> (rsp_rdata == 64'h0))
		else $error("write reply carries data");
	busy_after_a: assert property (@(posedge clock) disable iff (!rst_b)
		s_take_legal |=> !req_ready)
		else $error("second access taken before reply");
	idle_again_a: assert property (@(posedge clock) disable iff (!rst_b)
		(rsp_valid && rsp_ready) |=> req_ready)
		else $error("not ready after reply accepted");
	xlate_half_a: assert property (@(posedge clock) disable iff (!rst_b)
		(take && req_size == MRF_SZ_16 && is_xlate && req_addr[1:0] == 2'b00) |=> s_okay_reply)
		else $error("16-bit translate access refused");
endmodule : mrf_front
`default_nettype wire

// ---- core/mrf_pkg.sv ----
`default_nettype none
package mrf_pkg;
	// access size encodings on the request port
	typedef enum logic [1:0] {
		MRF_SZ_8 = 2'b00,
		MRF_SZ_16 = 2'b01,
		MRF_SZ_32 = 2'b10,
		MRF_SZ_64 = 2'b11
	} mrf_size_t;
	// response codes
	typedef enum logic [1:0] {
		MRF_RSP_OKAY = 2'b00,
		MRF_RSP_ABORT = 2'b10
	} mrf_resp_t;
	// reply pipe state
	typedef enum logic [0:0] {
		MRF_IDLE = 1'b0,
		MRF_RESP = 1'b1
	} mrf_state_t;
endpackage : mrf_pkg
`default_nettype wire

// ---- core/mrf_wr_if.sv ----
`default_nettype none
// write strobes from the decoder to every register frame, with frame_sel picking the addressed one
interface mrf_wr_if #(parameter int FRAMES = 2);
	logic [FRAMES-1:0] frame_sel;
	logic [11:0] offset;
	logic [63:0] wdata;
	logic [7:0] wstrb;
	logic wen;
	logic [63:0] rdata [FRAMES];
	modport ctl (output frame_sel, output offset, output wdata, output wstrb, output wen, input rdata);
	modport frm (input frame_sel, input offset, input wdata, input wstrb, input wen, output rdata);
endinterface : mrf_wr_if
`default_nettype wire
